// ==== pmc_pkg.sv ====
// shared constants and types for the power monitor control block
package pmc_pkg;

  // --------------------------------------------------------------
  // command codes of the reachable registers
  // --------------------------------------------------------------
  localparam logic [7:0] CMD_AUX_PEAK = 8'hD2;
  localparam logic [7:0] CMD_RUN_CTRL = 8'hD3;
  localparam logic [7:0] CMD_SAMPLE_CFG = 8'hD4;
  localparam logic [7:0] CMD_ALERT_EN = 8'hD5;

  // --------------------------------------------------------------
  // reset values and field layout
  // --------------------------------------------------------------
  localparam logic [15:0] AUX_PEAK_RESET = 16'h0000;
  localparam logic [15:0] AUX_PEAK_CLEAR = 16'h0000;
  localparam logic [7:0] RUN_CTRL_RESET = 8'h01;
  localparam logic [7:0] SAMPLE_CFG_RESET = 8'h8F;
  localparam logic [15:0] ALERT_EN_RESET = 16'h8000;
  localparam int RUN_BIT = 0;
  localparam int MODE_BIT = 7;
  localparam int AUX_EN_BIT = 6;
  localparam int RANGE_LSB = 3;
  localparam int RANGE_MSB = 4;
  localparam int AVG_LSB = 0;
  localparam int AVG_MSB = 2;
  localparam int FET_ALERT_BIT = 15;
  localparam int OC_ALERT_BIT = 14;
  localparam int OV_ALERT_BIT = 13;
  localparam logic [1:0] RANGE_25MV = 2'h1;
  localparam logic [1:0] RANGE_50MV = 2'h2;

  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int SAMPLE_W = 12;
  localparam int AVG_CODE_W = 3;
  localparam int NUM_CH = 3;
  localparam logic [7:0] ROUND_ONE = 8'h01;

  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] wdata;
  } pmc_cmd_t;

  typedef enum logic [1:0] {
    CH_VIN = 2'b00,
    CH_OUTPUT_CURRENT = 2'b01,
    CH_AUX = 2'b10
  } pmc_chan_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CONVERT = 2'b01,
    ST_WAIT = 2'b10,
    ST_ROUND = 2'b11
  } pmc_state_t;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_PEAK = 3'b001,
    SEL_RUN = 3'b010,
    SEL_CFG = 3'b011,
    SEL_ALERT = 3'b100
  } pmc_sel_t;

endpackage

// ==== pmc_channel_averager.sv ====
// accumulator that averages one telemetry channel over a power-of-two count
module pmc_channel_averager
  import pmc_pkg::*;
#(
  parameter int SAMPLE_WIDTH = SAMPLE_W,
  parameter int CODE_WIDTH = AVG_CODE_W
) (
  input wire logic core_clk_in, // device clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic clear_in, // restart accumulation
  input wire logic sample_valid_in, // one new sample
  input wire logic [SAMPLE_WIDTH-1:0] sample_in, // sample code
  input wire logic [CODE_WIDTH-1:0] avg_code_in, // log2 of sample count
  output logic [SAMPLE_WIDTH-1:0] average_out // mean of accumulated samples
);

  localparam int ACC_W = SAMPLE_WIDTH + (1 << CODE_WIDTH) - 1;

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_shift;

  // --------------------------------------------------------------
  // accumulate
  // --------------------------------------------------------------
  // clear and a sample in the same cycle start a fresh sum with it
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      acc_q <= '0;
    end else if (clear_in) begin
      acc_q <= sample_valid_in ? ACC_W'(sample_in) : '0;
    end else if (sample_valid_in) begin
      acc_q <= acc_q + ACC_W'(sample_in);
    end
  end

  // --------------------------------------------------------------
  // divide by shifting; the count is always a power of two
  // --------------------------------------------------------------
  always_comb begin
    acc_shift = acc_q >> avg_code_in;
    average_out = acc_shift[SAMPLE_WIDTH-1:0];
  end

endmodule

// ==== pmc_monitor_control.sv ====
// power monitor sampling control, peak hold and alert enables
module pmc_monitor_control
  import pmc_pkg::*;
#(
  parameter logic [1:0] SENSE_RANGE_RESET = RANGE_25MV
) (
  input wire logic core_clk_in, // device clock, 125 MHz
  input wire logic reset_n_in, // async reset, active low
  input wire pmc_cmd_t cmd_in, // decoded bus command
  output logic [15:0] rdata_out, // read data
  output logic rack_out, // read data valid pulse
  output logic cmd_err_out, // unmapped command pulse
  output logic adc_start_out, // conversion request pulse
  output logic [1:0] adc_channel_out, // channel to convert
  input wire logic adc_done_in, // conversion finished pulse
  input wire logic [SAMPLE_W-1:0] adc_data_in, // conversion result
  input wire logic fet_fault_status_in, // fet health fault flag
  input wire logic overcurrent_fault_status_in, // overcurrent fault flag
  input wire logic input_overvoltage_status_in, // input overvoltage flag
  output logic alert_out, // alert request, active high
  output logic [1:0] sense_range_select_out, // current sense range
  output logic monitor_busy_out, // sampling in progress
  output logic result_valid_out, // new averages pulse
  output logic [SAMPLE_W-1:0] vin_avg_out, // averaged input voltage
  output logic [SAMPLE_W-1:0] output_current_avg_out, // averaged output current
  output logic [SAMPLE_W-1:0] aux_voltage_avg_out // averaged aux voltage
);

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  function automatic pmc_sel_t decode_cmd(input logic [7:0] code);
    pmc_sel_t sel;
    sel = SEL_NONE;
    if (code == CMD_AUX_PEAK) begin
      sel = SEL_PEAK;
    end else if (code == CMD_RUN_CTRL) begin
      sel = SEL_RUN;
    end else if (code == CMD_SAMPLE_CFG) begin
      sel = SEL_CFG;
    end else if (code == CMD_ALERT_EN) begin
      sel = SEL_ALERT;
    end
    return sel;
  endfunction

  pmc_sel_t wr_sel;
  pmc_sel_t rd_sel;
  logic wr_peak;
  logic wr_run;
  logic wr_cfg;
  logic wr_alert;

  always_comb begin
    wr_sel = decode_cmd(cmd_in.code);
    rd_sel = decode_cmd(cmd_in.code);
    wr_peak = cmd_in.wr && (wr_sel == SEL_PEAK);
    wr_run = cmd_in.wr && (wr_sel == SEL_RUN);
    wr_cfg = cmd_in.wr && (wr_sel == SEL_CFG);
    wr_alert = cmd_in.wr && (wr_sel == SEL_ALERT);
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  logic run_q;
  logic mode_q;
  logic aux_en_q;
  logic [1:0] range_q;
  logic [AVG_CODE_W-1:0] avg_q;
  logic fet_alert_en_q;
  logic oc_alert_en_q;
  logic ov_alert_en_q;
  logic [SAMPLE_W-1:0] peak_q;

  pmc_state_t state_q;
  pmc_chan_t chan_q;
  logic [7:0] round_q;
  logic cyc_aux_q;
  logic [AVG_CODE_W-1:0] cyc_avg_q;
  logic round_last;
  logic cycle_done;
  logic start_cycle;
  logic [NUM_CH-1:0] sample_valid;
  logic avg_clear;
  logic [SAMPLE_W-1:0] avg_result [NUM_CH];

  always_comb begin
    round_last = (round_q == ((ROUND_ONE << cyc_avg_q) - ROUND_ONE));
    // a stop landing in the last round must not publish a partial result
    cycle_done = run_q && (state_q == ST_ROUND) && round_last;
    start_cycle = run_q && ((state_q == ST_IDLE) || cycle_done);
    avg_clear = start_cycle;
  end

  // run bit: a host write wins over the self-clear in the same cycle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_q <= RUN_CTRL_RESET[RUN_BIT];
    end else if (wr_run) begin
      run_q <= cmd_in.wdata[RUN_BIT];
    end else if (cycle_done && !mode_q) begin
      run_q <= 1'b0;
    end
  end

  // reserved range codes are refused and the old range is kept
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_q <= SAMPLE_CFG_RESET[MODE_BIT];
      aux_en_q <= SAMPLE_CFG_RESET[AUX_EN_BIT];
      range_q <= SENSE_RANGE_RESET;
      avg_q <= SAMPLE_CFG_RESET[AVG_MSB:AVG_LSB];
    end else if (wr_cfg) begin
      mode_q <= cmd_in.wdata[MODE_BIT];
      aux_en_q <= cmd_in.wdata[AUX_EN_BIT];
      avg_q <= cmd_in.wdata[AVG_MSB:AVG_LSB];
      if ((cmd_in.wdata[RANGE_MSB:RANGE_LSB] == RANGE_25MV) ||
          (cmd_in.wdata[RANGE_MSB:RANGE_LSB] == RANGE_50MV)) begin
        range_q <= cmd_in.wdata[RANGE_MSB:RANGE_LSB];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fet_alert_en_q <= ALERT_EN_RESET[FET_ALERT_BIT];
      oc_alert_en_q <= ALERT_EN_RESET[OC_ALERT_BIT];
      ov_alert_en_q <= ALERT_EN_RESET[OV_ALERT_BIT];
    end else if (wr_alert) begin
      fet_alert_en_q <= cmd_in.wdata[FET_ALERT_BIT];
      oc_alert_en_q <= cmd_in.wdata[OC_ALERT_BIT];
      ov_alert_en_q <= cmd_in.wdata[OV_ALERT_BIT];
    end
  end

  // --------------------------------------------------------------
  // aux peak hold
  // --------------------------------------------------------------
  // a new result in the clear cycle is kept, so no peak is lost
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      peak_q <= AUX_PEAK_RESET[SAMPLE_W-1:0];
    end else if (cycle_done && cyc_aux_q &&
                 ((avg_result[CH_AUX] > peak_q) ||
                  (wr_peak && cmd_in.wdata == AUX_PEAK_CLEAR))) begin
      peak_q <= avg_result[CH_AUX];
    end else if (wr_peak && (cmd_in.wdata == AUX_PEAK_CLEAR)) begin
      peak_q <= AUX_PEAK_CLEAR[SAMPLE_W-1:0];
    end
  end

  // --------------------------------------------------------------
  // sampling sequencer
  // --------------------------------------------------------------
  // settings are latched per cycle so a mid-cycle write cannot mix counts
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      chan_q <= CH_VIN;
      round_q <= '0;
      cyc_aux_q <= 1'b0;
      cyc_avg_q <= '0;
    end else if (!run_q) begin
      state_q <= ST_IDLE;
      chan_q <= CH_VIN;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_CONVERT;
          chan_q <= CH_VIN;
          round_q <= '0;
          cyc_aux_q <= aux_en_q;
          cyc_avg_q <= avg_q;
        end
        ST_CONVERT: begin
          state_q <= ST_WAIT;
        end
        ST_WAIT: begin
          if (adc_done_in) begin
            if (chan_q == CH_VIN) begin
              chan_q <= CH_OUTPUT_CURRENT;
              state_q <= ST_CONVERT;
            end else if ((chan_q == CH_OUTPUT_CURRENT) && cyc_aux_q) begin
              chan_q <= CH_AUX;
              state_q <= ST_CONVERT;
            end else begin
              state_q <= ST_ROUND;
            end
          end
        end
        ST_ROUND: begin
          chan_q <= CH_VIN;
          if (round_last) begin
            if (mode_q) begin
              state_q <= ST_CONVERT;
              round_q <= '0;
              cyc_aux_q <= aux_en_q;
              cyc_avg_q <= avg_q;
            end else begin
              state_q <= ST_IDLE;
            end
          end else begin
            state_q <= ST_CONVERT;
            round_q <= round_q + ROUND_ONE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      adc_start_out <= 1'b0;
      adc_channel_out <= CH_VIN;
      monitor_busy_out <= 1'b0;
    end else begin
      adc_start_out <= run_q && (state_q == ST_CONVERT);
      adc_channel_out <= chan_q;
      monitor_busy_out <= run_q && (state_q != ST_IDLE);
    end
  end

  // --------------------------------------------------------------
  // averaging per channel
  // --------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_avg
      assign sample_valid[ch] = run_q && (state_q == ST_WAIT) && adc_done_in &&
                                (chan_q == pmc_chan_t'(ch));
      pmc_channel_averager #(
        .SAMPLE_WIDTH(SAMPLE_W),
        .CODE_WIDTH(AVG_CODE_W)
      ) u_avg (
        .core_clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .clear_in(avg_clear),
        .sample_valid_in(sample_valid[ch]),
        .sample_in(adc_data_in),
        .avg_code_in(cyc_avg_q),
        .average_out(avg_result[ch])
      );
    end
  endgenerate

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      result_valid_out <= 1'b0;
      vin_avg_out <= '0;
      output_current_avg_out <= '0;
      aux_voltage_avg_out <= '0;
    end else begin
      result_valid_out <= cycle_done;
      if (cycle_done) begin
        vin_avg_out <= avg_result[CH_VIN];
        output_current_avg_out <= avg_result[CH_OUTPUT_CURRENT];
        if (cyc_aux_q) begin
          aux_voltage_avg_out <= avg_result[CH_AUX];
        end
      end
    end
  end

  // --------------------------------------------------------------
  // alert and outputs
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alert_out <= 1'b0;
      sense_range_select_out <= SENSE_RANGE_RESET;
    end else begin
      alert_out <= (fet_alert_en_q && fet_fault_status_in) ||
                   (oc_alert_en_q && overcurrent_fault_status_in) ||
                   (ov_alert_en_q && input_overvoltage_status_in);
      sense_range_select_out <= range_q;
    end
  end

  // --------------------------------------------------------------
  // read path
  // --------------------------------------------------------------
  logic [15:0] rd_word;

  always_comb begin
    rd_word = '0;
    if (rd_sel == SEL_PEAK) begin
      rd_word = {4'h0, peak_q};
    end else if (rd_sel == SEL_RUN) begin
      rd_word = {8'h00, 7'h00, run_q};
    end else if (rd_sel == SEL_CFG) begin
      rd_word = {8'h00, mode_q, aux_en_q, 1'b0, range_q, avg_q};
    end else if (rd_sel == SEL_ALERT) begin
      rd_word = {fet_alert_en_q, oc_alert_en_q, ov_alert_en_q, 13'h0000};
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_out <= '0;
      rack_out <= 1'b0;
      cmd_err_out <= 1'b0;
    end else begin
      rack_out <= cmd_in.rd;
      rdata_out <= cmd_in.rd ? rd_word : '0;
      cmd_err_out <= (cmd_in.rd || cmd_in.wr) && (rd_sel == SEL_NONE);
    end
  end

endmodule

// ==== pmc_monitor_control_asserts.sv ====
// concurrent checks on the ports of the power monitor control block
module pmc_monitor_control_asserts
  import pmc_pkg::*;
(
  input wire logic core_clk_in, // device clock
  input wire logic reset_n_in, // async reset
  input wire pmc_cmd_t cmd_in, // bus command
  input wire logic [15:0] rdata_out, // read word
  input wire logic rack_out, // read valid
  input wire logic adc_start_out, // convert pulse
  input wire logic [1:0] adc_channel_out, // channel
  input wire logic fet_fault_status_in, // fet fault
  input wire logic overcurrent_fault_status_in, // overcurrent
  input wire logic input_overvoltage_status_in, // overvoltage
  input wire logic alert_out, // alert level
  input wire logic [1:0] sense_range_select_out, // range code
  input wire logic monitor_busy_out, // busy level
  input wire logic result_valid_out, // result pulse
  input wire logic [SAMPLE_W-1:0] aux_voltage_avg_out // aux average
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [15:0] alert_en_q;
  logic [SAMPLE_W-1:0] aux_max_q;
  logic [SAMPLE_W-1:0] aux_bound;
  logic alert_exp;
  // ----------------------------------------------------------------
  // helper mirrors
  // ----------------------------------------------------------------
  // bound counts a result landing in the read cycle, peak may take it at once
  assign aux_bound = (result_valid_out && aux_voltage_avg_out > aux_max_q) ?
    aux_voltage_avg_out : aux_max_q;
  assign alert_exp = |(alert_en_q[15:13] & {fet_fault_status_in,
    overcurrent_fault_status_in, input_overvoltage_status_in});
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alert_en_q <= ALERT_EN_RESET;
    end else if (cmd_in.wr && cmd_in.code == CMD_ALERT_EN) begin
      alert_en_q <= cmd_in.wdata;
    end
  end
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aux_max_q <= '0;
    end else if (result_valid_out && aux_voltage_avg_out > aux_max_q) begin
      aux_max_q <= aux_voltage_avg_out;
    end else if (cmd_in.wr && cmd_in.code == CMD_AUX_PEAK && cmd_in.wdata == AUX_PEAK_CLEAR) begin
      aux_max_q <= '0;
    end
  end
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  peak_rsvd_a: assert property (rack_out && $past(cmd_in.code) == CMD_AUX_PEAK |->
    rdata_out[15:12] == 4'h0) else $error("peak upper bits not zero");
  peak_bound_a: assert property (rack_out && $past(cmd_in.code) == CMD_AUX_PEAK |->
    rdata_out[11:0] <= aux_bound) else $error("peak above any aux result");
  run_rsvd_a: assert property (rack_out && $past(cmd_in.code) == CMD_RUN_CTRL |->
    rdata_out[15:1] == 15'h0000) else $error("run control upper bits not zero");
  alert_map_a: assert property ($past(reset_n_in, 2) |->
    alert_out == $past(alert_exp)) else $error("alert differs from enabled faults");
  range_legal_a: assert property (sense_range_select_out == RANGE_25MV ||
    sense_range_select_out == RANGE_50MV) else $error("reserved sense range driven");
  start_busy_a: assert property (adc_start_out |-> monitor_busy_out)
    else $error("conversion started while idle");
  start_pulse_a: assert property (adc_start_out |=> !adc_start_out)
    else $error("start longer than one cycle");
  chan_legal_a: assert property (adc_start_out |-> adc_channel_out != 2'h3)
    else $error("unknown channel requested");
  stop_idle_a: assert property (cmd_in.wr && cmd_in.code == CMD_RUN_CTRL &&
    !cmd_in.wdata[RUN_BIT] |-> ##[1:3] !monitor_busy_out) else $error("busy after stop");
  cover property (rack_out && $past(cmd_in.code) == CMD_AUX_PEAK);
  cover property (result_valid_out);
  cover property (alert_out);
endmodule

bind pmc_monitor_control pmc_monitor_control_asserts u_asserts (
  .core_clk_in, .reset_n_in, .cmd_in, .rdata_out, .rack_out, .adc_start_out,
  .adc_channel_out, .fet_fault_status_in, .overcurrent_fault_status_in,
  .input_overvoltage_status_in, .alert_out, .sense_range_select_out,
  .monitor_busy_out, .result_valid_out, .aux_voltage_avg_out
);

// ==== pmc_adc_model.sv ====
// behavioural converter answering start pulses after a set latency
module pmc_adc_model
  import pmc_pkg::*;
(
  input wire logic clk_in, // device clock
  input wire logic rst_n_in, // async reset
  input wire logic start_in, // convert request
  input wire logic [1:0] chan_in, // channel
  input wire logic [3:0] lat_in, // extra wait cycles
  input wire logic [SAMPLE_W-1:0] vin_in, // vin code
  input wire logic [SAMPLE_W-1:0] output_current_in, // current code
  input wire logic [SAMPLE_W-1:0] aux_in, // aux code
  output logic done_out, // result pulse
  output logic [SAMPLE_W-1:0] data_out // result code
);
  logic busy_q;
  logic odd_q;
  logic [3:0] cnt_q;
  logic [SAMPLE_W-1:0] val_q;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      odd_q <= 1'b0;
      cnt_q <= 4'h0;
      val_q <= '0;
      done_out <= 1'b0;
      data_out <= '0;
    end else begin
      done_out <= 1'b0;
      // data only good with done, toggled otherwise so stale sampling shows
      data_out <= ~data_out;
      if (start_in) begin
        busy_q <= 1'b1;
        cnt_q <= lat_in;
        odd_q <= ~odd_q;
        // lsb alternates so averaging truncation is exercised
        val_q <= (chan_in == 2'h0 ? vin_in : chan_in == 2'h1 ? output_current_in : aux_in) ^
          {11'h000, odd_q};
      end else if (busy_q && cnt_q == 4'h0) begin
        busy_q <= 1'b0;
        done_out <= 1'b1;
        data_out <= val_q;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 4'h1;
      end
    end
  end
endmodule

// ==== pmc_monitor_control_bench.sv ====
// self-checking bench for the power monitor control block
module pmc_monitor_control_bench
  import pmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, rack, err, start, done, alert, busy, res, fet, oc, ov;
  pmc_cmd_t cmd;
  logic [15:0] rdata, w;
  logic [1:0] chan, range_o;
  logic [2:0] st;
  logic [3:0] lat;
  logic [11:0] adata, vin_a, output_current_a, aux_a, v_vin, v_output_current, v_aux, a1;
  logic [7:0] cfg_cur;
  int failures, cmp_count, n;
  int seed = 32'h759E;

  pmc_monitor_control u_dut (.core_clk_in(clk), .reset_n_in(rst_n), .cmd_in(cmd),
    .rdata_out(rdata), .rack_out(rack), .cmd_err_out(err), .adc_start_out(start),
    .adc_channel_out(chan), .adc_done_in(done), .adc_data_in(adata),
    .fet_fault_status_in(fet), .overcurrent_fault_status_in(oc),
    .input_overvoltage_status_in(ov), .alert_out(alert), .sense_range_select_out(range_o),
    .monitor_busy_out(busy), .result_valid_out(res), .vin_avg_out(vin_a),
    .output_current_avg_out(output_current_a), .aux_voltage_avg_out(aux_a));
  pmc_adc_model u_adc (.clk_in(clk), .rst_n_in(rst_n), .start_in(start), .chan_in(chan),
    .lat_in(lat), .vin_in(v_vin), .output_current_in(v_output_current), .aux_in(v_aux), .done_out(done),
    .data_out(adata));

  always #4 clk = ~clk;
  // ----------------------------------------------------------------
  // helpers, all entered and left at a falling edge except conclude, which the watchdog calls at a rising edge
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp, input string what);
    chk_word({15'h0000, got}, {15'h0000, exp}, what);
  endtask
  task automatic reg_rd(input logic [7:0] code, input logic [15:0] exp, input logic exp_err);
    // one idle edge between requests, so a strobe is never dropped and raised at once
    @(negedge clk);
    cmd.rd = 1'b1;
    cmd.code = code;
    @(negedge clk);
    cmd.rd = 1'b0;
    chk_bit(rack, 1'b1, "read ack");
    chk_bit(err, exp_err, "command error");
    chk_word(rdata, exp, "read data");
  endtask
  task automatic reg_wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk);
    cmd.wr = 1'b1;
    cmd.code = code;
    cmd.wdata = data;
    @(negedge clk);
    cmd.wr = 1'b0;
  endtask
  task automatic wait_res;
    n = 0;
    while (res !== 1'b1 && n < 8000) begin
      @(negedge clk);
      n++;
    end
    chk_bit(res, 1'b1, "sampling result");
    @(negedge clk);
  endtask
  // two results so a cycle mixing old and new inputs is flushed
  task automatic settle;
    wait_res;
    wait_res;
    repeat (3) @(negedge clk);
  endtask
  task automatic quiet_span;
    n = 0;
    repeat (200) begin
      @(negedge clk);
      n += int'(start === 1'b1 || res === 1'b1);
    end
    chk_word(16'(n), 16'h0000, "activity while stopped");
  endtask
  function automatic logic [7:0] exp_cfg(input logic [7:0] old, input logic [7:0] wv);
    logic [1:0] rng;
    rng = (wv[4:3] == RANGE_25MV || wv[4:3] == RANGE_50MV) ? wv[4:3] : old[4:3];
    return {wv[7:6], 1'b0, rng, wv[2:0]};
  endfunction
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude;
  end
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    cmd = '0;
    {fet, oc, ov} = 3'h0;
    lat = 4'h0;
    {v_vin, v_output_current, v_aux} = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    reg_rd(CMD_AUX_PEAK, AUX_PEAK_RESET, 1'b0);
    reg_rd(CMD_RUN_CTRL, 16'h0001, 1'b0);
    reg_rd(CMD_SAMPLE_CFG, 16'h008F, 1'b0);
    reg_rd(CMD_ALERT_EN, 16'h8000, 1'b0);
    reg_rd(8'hD6, 16'h0000, 1'b1);
    fet = 1'b1;
    repeat (2) @(negedge clk);
    chk_bit(alert, 1'b1, "alert at power-up");
    for (int i = 0; i < 12; i++) begin
      w = (i < 6) ? (16'h8000 >> (i % 3)) : 16'($random(seed));
      st = (i < 3) ? 3'h7 : (i < 6) ? ~(3'h4 >> (i % 3)) : 3'($random(seed));
      reg_wr(CMD_ALERT_EN, w);
      reg_rd(CMD_ALERT_EN, w & 16'hE000, 1'b0);
      {fet, oc, ov} = st;
      repeat (2) @(negedge clk);
      chk_bit(alert, |(w[15:13] & st), "alert");
    end
    reg_wr(CMD_RUN_CTRL, 16'h00FF);
    reg_rd(CMD_RUN_CTRL, 16'h0001, 1'b0);
    cfg_cur = SAMPLE_CFG_RESET;
    for (int i = 0; i < 8; i++) begin
      w = 16'($random(seed));
      w[4:3] = i[1:0];
      w[7] = 1'b1;
      reg_wr(CMD_SAMPLE_CFG, w);
      cfg_cur = exp_cfg(cfg_cur, w[7:0]);
      reg_rd(CMD_SAMPLE_CFG, {8'h00, cfg_cur}, 1'b0);
    end
    lat = 4'($random(seed)) & 4'h3;
    v_vin = 12'($random(seed)) & 12'hFFE;
    v_output_current = 12'($random(seed)) & 12'hFFE;
    a1 = 12'h800 + (12'($random(seed)) & 12'h3FE);
    v_aux = a1;
    reg_wr(CMD_SAMPLE_CFG, 16'h00D1);
    settle;
    chk_word({4'h0, vin_a}, {4'h0, v_vin}, "vin average");
    chk_word({4'h0, output_current_a}, {4'h0, v_output_current}, "current average");
    chk_word({4'h0, aux_a}, {4'h0, a1}, "aux average");
    chk_word({14'h0000, range_o}, 16'h0002, "sense range");
    // a cycle straddling the input change may leave an odd code in the peak
    reg_wr(CMD_AUX_PEAK, AUX_PEAK_CLEAR);
    settle;
    reg_rd(CMD_AUX_PEAK, {4'h0, a1}, 1'b0);
    reg_wr(CMD_AUX_PEAK, 16'hF123);
    reg_rd(CMD_AUX_PEAK, {4'h0, a1}, 1'b0);
    v_aux = a1 - 12'h100;
    settle;
    reg_wr(CMD_AUX_PEAK, AUX_PEAK_CLEAR);
    settle;
    reg_rd(CMD_AUX_PEAK, {4'h0, v_aux}, 1'b0);
    v_aux = a1 + 12'h100;
    settle;
    reg_rd(CMD_AUX_PEAK, {4'h0, v_aux}, 1'b0);
    v_aux = a1;
    settle;
    reg_rd(CMD_AUX_PEAK, {4'h0, a1 + 12'h100}, 1'b0);
    reg_wr(CMD_RUN_CTRL, 16'h0000);
    repeat (3) @(negedge clk);
    chk_bit(busy, 1'b0, "busy after stop");
    quiet_span;
    reg_wr(CMD_SAMPLE_CFG, 16'h0051);
    reg_rd(CMD_SAMPLE_CFG, 16'h0051, 1'b0);
    reg_wr(CMD_RUN_CTRL, 16'h0001);
    wait_res;
    repeat (3) @(negedge clk);
    reg_rd(CMD_RUN_CTRL, 16'h0000, 1'b0);
    quiet_span;
    conclude;
  end
endmodule
